// *** design/dcc_edge_flags.sv ***
// sticky rising and falling edge flags, set wins over a software write
`timescale 1ns/1ps
`default_nettype none
module dcc_edge_flags
	import dcc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// hardware set pulses
	input wire dcc_flag_s set_in,
	// software write
	input wire logic wr_in,
	input wire dcc_flag_s wdata_in,
	// flag state
	output dcc_flag_s flags_out
);
	dcc_flag_s flags_reg;
	dcc_flag_s flags_next;

	always_comb begin
		flags_next = flags_reg;
		if (wr_in) begin
			flags_next = wdata_in;
		end
		flags_next.rise = flags_next.rise | set_in.rise;
		flags_next.fall = flags_next.fall | set_in.fall;
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			flags_reg <= '{rise: 1'b0, fall: 1'b0};
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags_out = flags_reg;
endmodule // dcc_edge_flags
`default_nettype wire

// *** design/dcc_regs.sv ***
// register bank for the two comparators: mode, control, flags, requests
// Notes on behaviour
// - cmp0 mode bit 5 enables the cmp0 rising-edge interrupt request.
// - cmp0 mode bit 4 enables the cmp0 falling-edge interrupt request.
// - cmp1 mode bits 5 and 4 enable rising and falling requests.
// - cmp0 mode bits 1:0 pick speed, 00 fastest to 11 lowest power.
// - cmp1 mode bits 1:0 pick cmp1 speed the same way.
// - mode bit 7 reads one; software always writes one there.
// - mode bits 6, 3, 2 read zero and ignore writes.
// - cmp1 control bit 7 switches comparator 1 on.
// - cmp1 control bit 6 is read-only comparator result.
// - cmp1 control bit 5 latches on rising edge until written zero.
// - cmp1 control bit 4 latches on falling edge until written zero.
// - cmp1 control bits 3:2 select positive hysteresis, 00 off.
// - cmp1 control bits 1:0 select negative hysteresis, 00 off.
// - cmp0 mode decodes on every page; cmp1 registers on page zero.
// - both comparator results are offered to the timers.
// - edge flags set on every edge while the comparator is on, regardless of interrupt enables.
// - request needs flag, edge enable, source enable and global enable.
`timescale 1ns/1ps
`default_nettype none
module dcc_regs
	import dcc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// special function register bus
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_page_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	output logic sfr_rd_hit_out,
	// raw analog comparator outputs
	input wire logic cmp0_raw_in,
	input wire logic cmp1_raw_in,
	// comparator 0 control held outside this bank
	input wire logic cmp0_enable_in,
	input wire logic cmp0_rise_clr_in,
	input wire logic cmp0_fall_clr_in,
	// interrupt gating
	input wire logic cmp_irq_src_en_in,
	input wire logic global_irq_en_in,
	// analog settings
	output logic cmp1_enable_out,
	output logic [1:0] cmp1_pos_hyst_out,
	output logic [1:0] cmp1_neg_hyst_out,
	output logic [1:0] cmp0_speed_mode_out,
	output logic [1:0] cmp1_speed_mode_out,
	// status
	output logic cmp0_result_out,
	output logic cmp1_result_out,
	output logic cmp0_rise_flag_out,
	output logic cmp0_fall_flag_out,
	// timer capture feeds
	output logic [1:0] cmp_timer_out,
	// interrupt requests
	output logic cmp0_irq_out,
	output logic cmp1_irq_out
);

	// address match with optional page qualification
	function automatic logic dcc_hit(
		input logic [7:0] addr,
		input logic [7:0] page,
		input logic [7:0] target,
		input logic any_page
	);
		dcc_hit = (addr == target) && (any_page || (page == DCC_PAGE_ZERO));
	endfunction

	// mode register image: fixed one, unused zeros
	function automatic logic [7:0] dcc_mode_byte(input dcc_mode_s m);
		logic [7:0] b;
		b = 8'h00;
		b[DCC_MODE_FIXED_BIT] = 1'b1;
		b[DCC_MODE_RIE_BIT] = m.rise_irq_en;
		b[DCC_MODE_FIE_BIT] = m.fall_irq_en;
		b[DCC_MODE_MD_LSB +: 2] = m.speed_mode;
		dcc_mode_byte = b;
	endfunction

	// pick the writable mode fields out of a bus byte
	function automatic dcc_mode_s dcc_mode_fields(input logic [7:0] d);
		dcc_mode_s m;
		m.rise_irq_en = d[DCC_MODE_RIE_BIT];
		m.fall_irq_en = d[DCC_MODE_FIE_BIT];
		m.speed_mode = d[DCC_MODE_MD_LSB +: 2];
		dcc_mode_fields = m;
	endfunction

	// request from flags and enables
	function automatic logic dcc_irq(
		input dcc_flag_s f,
		input dcc_mode_s m,
		input logic src_en,
		input logic glb_en
	);
		dcc_irq = src_en & glb_en &
			((f.rise & m.rise_irq_en) | (f.fall & m.fall_irq_en));
	endfunction

	// hardware set pulses out of an edge record
	function automatic dcc_flag_s dcc_edge_set(input dcc_edge_s e);
		dcc_edge_set = '{rise: e.rise, fall: e.fall};
	endfunction

	// filtered level forced low while a comparator is off
	function automatic logic dcc_level(input dcc_edge_s e, input logic en);
		dcc_level = e.level & en;
	endfunction

	localparam dcc_mode_s MODE_RST = '{
		rise_irq_en: DCC_MODE_RST[DCC_MODE_RIE_BIT],
		fall_irq_en: DCC_MODE_RST[DCC_MODE_FIE_BIT],
		speed_mode: DCC_SPEED_RST
	};
	localparam dcc_ctrl_s CTRL_RST = '{
		enable: DCC_CTRL_RST[DCC_CTRL_EN_BIT],
		pos_hyst: DCC_HYST_RST,
		neg_hyst: DCC_HYST_RST
	};

	dcc_mode_s mode0_reg;
	dcc_mode_s mode1_reg;
	dcc_ctrl_s ctrl1_reg;
	dcc_edge_s edge0;
	dcc_edge_s edge1;
	dcc_flag_s flags0;
	dcc_flag_s flags1;
	dcc_flag_s flags0_wdata;
	dcc_flag_s flags1_wdata;
	logic hit_mode0;
	logic hit_mode1;
	logic hit_ctrl1;
	logic wr_mode0;
	logic wr_mode1;
	logic wr_ctrl1;
	logic wr_flags0;
	logic [7:0] rdata_next;
	logic rd_hit_next;
	logic [7:0] rdata_reg;
	logic rd_hit_reg;
	logic cmp0_result_reg;
	logic cmp1_result_reg;
	logic [1:0] cmp_timer_reg;
	logic cmp0_irq_reg;
	logic cmp1_irq_reg;

	// address decode
	assign hit_mode0 = dcc_hit(sfr_addr_in, sfr_page_in,
		DCC_CMP0_MODE_ADDR, 1'b1);
	assign hit_mode1 = dcc_hit(sfr_addr_in, sfr_page_in,
		DCC_CMP1_MODE_ADDR, 1'b0);
	assign hit_ctrl1 = dcc_hit(sfr_addr_in, sfr_page_in,
		DCC_CMP1_CTRL_ADDR, 1'b0);
	assign wr_mode0 = sfr_wr_in & hit_mode0;
	assign wr_mode1 = sfr_wr_in & hit_mode1;
	assign wr_ctrl1 = sfr_wr_in & hit_ctrl1;

	// comparator 0 mode register
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mode0_reg <= MODE_RST;
		end else if (wr_mode0) begin
			// bit 7 and the unused bits are not stored
			mode0_reg <= dcc_mode_fields(sfr_wdata_in);
		end
	end

	// comparator 1 mode register
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mode1_reg <= MODE_RST;
		end else if (wr_mode1) begin
			mode1_reg <= dcc_mode_fields(sfr_wdata_in);
		end
	end

	// comparator 1 control register, writable fields
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl1_reg <= CTRL_RST;
		end else if (wr_ctrl1) begin
			ctrl1_reg.enable <= sfr_wdata_in[DCC_CTRL_EN_BIT];
			ctrl1_reg.pos_hyst <= sfr_wdata_in[DCC_CTRL_HYP_LSB +: 2];
			ctrl1_reg.neg_hyst <= sfr_wdata_in[DCC_CTRL_HYN_LSB +: 2];
		end
	end

	// synchronise the raw outputs and find their edges
	dcc_sync_edge u_sync0 (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.raw_in(cmp0_raw_in),
		.enable_in(cmp0_enable_in),
		.edge_out(edge0)
	);

	dcc_sync_edge u_sync1 (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.raw_in(cmp1_raw_in),
		.enable_in(ctrl1_reg.enable),
		.edge_out(edge1)
	);

	// comparator 0 flags cleared by the outside control register
	assign wr_flags0 = cmp0_rise_clr_in | cmp0_fall_clr_in;
	assign flags0_wdata = '{
		rise: flags0.rise & ~cmp0_rise_clr_in,
		fall: flags0.fall & ~cmp0_fall_clr_in
	};

	// a write of one sets a flag, a write of zero clears it
	// an edge in the cycle of a clearing write still sets the flag
	assign flags1_wdata = '{
		rise: sfr_wdata_in[DCC_CTRL_RFLAG_BIT],
		fall: sfr_wdata_in[DCC_CTRL_FFLAG_BIT]
	};

	// flags set on edges whatever the interrupt enables say
	dcc_edge_flags u_flags0 (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.set_in(dcc_edge_set(edge0)),
		.wr_in(wr_flags0),
		.wdata_in(flags0_wdata),
		.flags_out(flags0)
	);

	dcc_edge_flags u_flags1 (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.set_in(dcc_edge_set(edge1)),
		.wr_in(wr_ctrl1),
		.wdata_in(flags1_wdata),
		.flags_out(flags1)
	);

	// filtered results, zero while a comparator is switched off
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cmp0_result_reg <= 1'b0;
		end else begin
			cmp0_result_reg <= dcc_level(edge0, cmp0_enable_in);
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cmp1_result_reg <= 1'b0;
		end else begin
			cmp1_result_reg <= dcc_level(edge1, ctrl1_reg.enable);
		end
	end

	// results to the timer capture inputs
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cmp_timer_reg <= 2'h0;
		end else begin
			cmp_timer_reg <= {cmp1_result_reg, cmp0_result_reg};
		end
	end

	// read multiplexer
	always_comb begin
		rdata_next = 8'h00;
		rd_hit_next = 1'b0;
		if (hit_mode0) begin
			rdata_next = dcc_mode_byte(mode0_reg);
			rd_hit_next = 1'b1;
		end else if (hit_mode1) begin
			rdata_next = dcc_mode_byte(mode1_reg);
			rd_hit_next = 1'b1;
		end else if (hit_ctrl1) begin
			rdata_next[DCC_CTRL_EN_BIT] = ctrl1_reg.enable;
			rdata_next[DCC_CTRL_OUT_BIT] = cmp1_result_reg;
			rdata_next[DCC_CTRL_RFLAG_BIT] = flags1.rise;
			rdata_next[DCC_CTRL_FFLAG_BIT] = flags1.fall;
			rdata_next[DCC_CTRL_HYP_LSB +: 2] = ctrl1_reg.pos_hyst;
			rdata_next[DCC_CTRL_HYN_LSB +: 2] = ctrl1_reg.neg_hyst;
			rd_hit_next = 1'b1;
		end
	end

	// read data registered on the read strobe, held until the next read
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_reg <= 8'h00;
		end else if (sfr_rd_in) begin
			rdata_reg <= rdata_next;
		end
	end

	// hit flag lasts one cycle after each mapped read
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_hit_reg <= 1'b0;
		end else begin
			rd_hit_reg <= sfr_rd_in & rd_hit_next;
		end
	end

	// interrupt requests
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cmp0_irq_reg <= 1'b0;
		end else begin
			cmp0_irq_reg <= dcc_irq(flags0, mode0_reg,
				cmp_irq_src_en_in, global_irq_en_in);
		end
	end

	// a pending flag raises the request as soon as the gates open
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cmp1_irq_reg <= 1'b0;
		end else begin
			cmp1_irq_reg <= dcc_irq(flags1, mode1_reg,
				cmp_irq_src_en_in, global_irq_en_in);
		end
	end

	// outputs
	assign sfr_rdata_out = rdata_reg;
	assign sfr_rd_hit_out = rd_hit_reg;
	assign cmp1_enable_out = ctrl1_reg.enable;
	assign cmp1_pos_hyst_out = ctrl1_reg.pos_hyst;
	assign cmp1_neg_hyst_out = ctrl1_reg.neg_hyst;
	assign cmp0_speed_mode_out = mode0_reg.speed_mode;
	assign cmp1_speed_mode_out = mode1_reg.speed_mode;
	assign cmp0_result_out = cmp0_result_reg;
	assign cmp1_result_out = cmp1_result_reg;
	assign cmp0_rise_flag_out = flags0.rise;
	assign cmp0_fall_flag_out = flags0.fall;
	assign cmp_timer_out = cmp_timer_reg;
	assign cmp0_irq_out = cmp0_irq_reg;
	assign cmp1_irq_out = cmp1_irq_reg;
endmodule // dcc_regs
`default_nettype wire

// *** design/dcc_sync_edge.sv ***
// synchroniser, glitch filter and edge detector for one comparator output
`timescale 1ns/1ps
`default_nettype none
module dcc_sync_edge
	import dcc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// raw comparator level and qualifier
	input wire logic raw_in,
	input wire logic enable_in,
	// filtered level and edge pulses
	output dcc_edge_s edge_out
);
	logic meta_reg;
	logic sync_a_reg;
	logic sync_b_reg;
	logic stable_reg;
	logic rise_reg;
	logic fall_reg;
	logic agree;

	// meta_reg is read only by sync_a_reg
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_reg <= 1'b0;
			sync_a_reg <= 1'b0;
			sync_b_reg <= 1'b0;
		end else begin
			meta_reg <= raw_in;
			sync_a_reg <= meta_reg;
			sync_b_reg <= sync_a_reg;
		end
	end

	assign agree = (sync_a_reg == sync_b_reg);

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stable_reg <= 1'b0;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end else begin
			if (agree) begin
				stable_reg <= sync_b_reg;
			end
			rise_reg <= agree & sync_b_reg & ~stable_reg & enable_in;
			fall_reg <= agree & ~sync_b_reg & stable_reg & enable_in;
		end
	end

	assign edge_out = '{level: stable_reg, rise: rise_reg, fall: fall_reg};
endmodule // dcc_sync_edge
`default_nettype wire

// *** shared/dcc_pkg.sv ***
// constants and carrier types for the dual comparator control registers
`default_nettype none
package dcc_pkg;
	// register addresses and page
	localparam logic [7:0] DCC_CMP1_CTRL_ADDR = 8'h9A;
	localparam logic [7:0] DCC_CMP1_MODE_ADDR = 8'h9C;
	localparam logic [7:0] DCC_CMP0_MODE_ADDR = 8'h9D;
	localparam logic [7:0] DCC_PAGE_ZERO = 8'h00;
	// control register field positions
	localparam int DCC_CTRL_EN_BIT = 7;
	localparam int DCC_CTRL_OUT_BIT = 6;
	localparam int DCC_CTRL_RFLAG_BIT = 5;
	localparam int DCC_CTRL_FFLAG_BIT = 4;
	localparam int DCC_CTRL_HYP_LSB = 2;
	localparam int DCC_CTRL_HYN_LSB = 0;
	// mode register field positions
	localparam int DCC_MODE_FIXED_BIT = 7;
	localparam int DCC_MODE_RIE_BIT = 5;
	localparam int DCC_MODE_FIE_BIT = 4;
	localparam int DCC_MODE_MD_LSB = 0;
	// reset values
	localparam logic [7:0] DCC_MODE_RST = 8'h82;
	localparam logic [7:0] DCC_CTRL_RST = 8'h00;
	localparam logic [1:0] DCC_SPEED_RST = 2'h2;
	localparam logic [1:0] DCC_HYST_RST = 2'h0;
	// input synchroniser depth
	localparam int DCC_SYNC_STAGES = 3;
	typedef struct packed {
		logic rise_irq_en;
		logic fall_irq_en;
		logic [1:0] speed_mode;
	} dcc_mode_s;
	typedef struct packed {
		logic enable;
		logic [1:0] pos_hyst;
		logic [1:0] neg_hyst;
	} dcc_ctrl_s;
	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} dcc_edge_s;
	typedef struct packed {
		logic rise;
		logic fall;
	} dcc_flag_s;
endpackage
`default_nettype wire

// *** test/dcc_cmp_model.sv ***
// behavioural pair of analog comparators feeding raw levels
`timescale 1ns/1ps
`default_nettype none
module dcc_cmp_model (
	// sign of each input difference, {cmp1, cmp0}
	input wire logic [1:0] level_in,
	// power and speed settings
	input wire logic cmp0_enable_in,
	input wire logic cmp1_enable_in,
	input wire logic [1:0] cmp0_speed_mode_in,
	input wire logic [1:0] cmp1_speed_mode_in,
	// raw asynchronous outputs
	output logic cmp0_raw_out,
	output logic cmp1_raw_out
);
	initial cmp0_raw_out = 1'h0;
	initial cmp1_raw_out = 1'h0;
	// slower modes answer later; shutdown holds the output low
	always @(level_in[0] or cmp0_enable_in)
		cmp0_raw_out <= #(1 + 5 * cmp0_speed_mode_in)
			level_in[0] & cmp0_enable_in;
	always @(level_in[1] or cmp1_enable_in)
		cmp1_raw_out <= #(1 + 5 * cmp1_speed_mode_in)
			level_in[1] & cmp1_enable_in;
endmodule // dcc_cmp_model
`default_nettype wire

// *** test/dcc_regs_chk.sv ***
// port assertions for the comparator register bank
`timescale 1ns/1ps
`default_nettype none
module dcc_regs_chk
	import dcc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// register bus
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_page_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic sfr_rd_hit_out,
	// gating and settings
	input wire logic cmp_irq_src_en_in,
	input wire logic global_irq_en_in,
	input wire logic cmp1_enable_out,
	input wire logic [1:0] cmp1_pos_hyst_out,
	input wire logic [1:0] cmp1_neg_hyst_out,
	input wire logic [1:0] cmp0_speed_mode_out,
	input wire logic [1:0] cmp1_speed_mode_out,
	// status
	input wire logic cmp0_result_out,
	input wire logic cmp1_result_out,
	input wire logic [1:0] cmp_timer_out,
	input wire logic cmp0_irq_out,
	input wire logic cmp1_irq_out
);
	wire p0 = sfr_page_in == DCC_PAGE_ZERO;
	wire m9d = sfr_addr_in == DCC_CMP0_MODE_ADDR;
	wire m9c = p0 && sfr_addr_in == DCC_CMP1_MODE_ADDR;
	wire m9a = p0 && sfr_addr_in == DCC_CMP1_CTRL_ADDR;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	a_mode_fixed_bits: assert property (
		sfr_rd_in && (m9d || m9c) |=> sfr_rdata_out[7] &&
		sfr_rdata_out[6] == 1'h0 && sfr_rdata_out[3:2] == 2'h0)
		else $error("mode fixed bits wrong");
	a_speed0_write: assert property (sfr_wr_in && m9d |=>
		cmp0_speed_mode_out == $past(sfr_wdata_in[1:0])) else $error("cmp0 speed");
	a_speed1_write: assert property (sfr_wr_in && m9c |=>
		cmp1_speed_mode_out == $past(sfr_wdata_in[1:0])) else $error("cmp1 speed");
	a_page_guard: assert property (sfr_wr_in && !p0 && !m9d |=>
		$stable(cmp1_speed_mode_out) && $stable(cmp1_enable_out))
		else $error("write taken off page zero");
	a_ctrl_write: assert property (sfr_wr_in && m9a |=>
		cmp1_enable_out == $past(sfr_wdata_in[7]) &&
		{cmp1_pos_hyst_out, cmp1_neg_hyst_out} == $past(sfr_wdata_in[3:0]))
		else $error("ctrl write");
	a_result_read: assert property (sfr_rd_in && m9a |=>
		sfr_rdata_out[6] == $past(cmp1_result_out)) else $error("result read");
	a_unmapped_read: assert property (
		sfr_rd_in && !(m9d || m9c || m9a) |=>
		!sfr_rd_hit_out && sfr_rdata_out == 8'h00) else $error("unmapped read");
	a_irq_gating: assert property (cmp0_irq_out || cmp1_irq_out |->
		$past(cmp_irq_src_en_in) && $past(global_irq_en_in))
		else $error("irq ungated");
	a_timer_follow: assert property (cmp_timer_out ==
		{$past(cmp1_result_out), $past(cmp0_result_out)})
		else $error("timer feed");
	c_irq0: cover property (cmp0_irq_out);
	c_irq1: cover property (cmp1_irq_out);
	c_rd_hit: cover property (sfr_rd_hit_out);
endmodule // dcc_regs_chk
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the comparator register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dcc_pkg::*;
	typedef struct packed {
		logic [7:0] wpg, wa, wd, rpg, exp;
		logic hit;
	} dcc_row_s;
	logic ref_clk_in = 1'h0;
	logic rst_b_in = 1'h0;
	logic [7:0] sfr_addr_in = 8'h00, sfr_page_in = 8'h00, sfr_wdata_in = 8'h00;
	logic sfr_wr_in = 1'h0, sfr_rd_in = 1'h0, cmp0_enable_in = 1'h0;
	logic cmp0_rise_clr_in = 1'h0, cmp0_fall_clr_in = 1'h0;
	logic cmp_irq_src_en_in = 1'h0, global_irq_en_in = 1'h0;
	logic [1:0] level = 2'h0;
	logic [7:0] sfr_rdata_out;
	logic [1:0] cmp1_pos_hyst_out, cmp1_neg_hyst_out, cmp_timer_out;
	logic [1:0] cmp0_speed_mode_out, cmp1_speed_mode_out;
	logic sfr_rd_hit_out, cmp0_raw_in, cmp1_raw_in, cmp1_enable_out;
	logic cmp0_result_out, cmp1_result_out, cmp0_rise_flag_out;
	logic cmp0_fall_flag_out, cmp0_irq_out, cmp1_irq_out;
	int bad_count = 0;
	int samples_checked = 0;
	dcc_row_s r [9] = '{
		'{8'h00, 8'h9D, 8'hFF, 8'h00, 8'hB3, 1'h1},
		'{8'h05, 8'h9D, 8'h8D, 8'h07, 8'h81, 1'h1},
		'{8'h00, 8'h9C, 8'hFE, 8'h00, 8'hB2, 1'h1},
		'{8'h01, 8'h9C, 8'h83, 8'h00, 8'hB2, 1'h1},
		'{8'h00, 8'h9C, 8'h93, 8'h01, 8'h00, 1'h0},
		'{8'h00, 8'h9A, 8'h7E, 8'h00, 8'h3E, 1'h1},
		'{8'h00, 8'h9A, 8'h8D, 8'h00, 8'h8D, 1'h1},
		'{8'h00, 8'h9B, 8'hFF, 8'h00, 8'h00, 1'h0},
		'{8'h02, 8'h9A, 8'h00, 8'h02, 8'h00, 1'h0}};
	dcc_regs dcc_regs_i (.ref_clk_in, .rst_b_in, .sfr_addr_in, .sfr_page_in,
		.sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .sfr_rd_hit_out,
		.cmp0_raw_in, .cmp1_raw_in, .cmp0_enable_in, .cmp0_rise_clr_in,
		.cmp0_fall_clr_in, .cmp_irq_src_en_in, .global_irq_en_in,
		.cmp1_enable_out, .cmp1_pos_hyst_out, .cmp1_neg_hyst_out,
		.cmp0_speed_mode_out, .cmp1_speed_mode_out, .cmp0_result_out,
		.cmp1_result_out, .cmp0_rise_flag_out, .cmp0_fall_flag_out,
		.cmp_timer_out, .cmp0_irq_out, .cmp1_irq_out);
	dcc_cmp_model dcc_cmp_model_i (.level_in(level), .cmp0_enable_in,
		.cmp1_enable_in(cmp1_enable_out), .cmp0_speed_mode_in(cmp0_speed_mode_out),
		.cmp1_speed_mode_in(cmp1_speed_mode_out), .cmp0_raw_out(cmp0_raw_in),
		.cmp1_raw_out(cmp1_raw_in));
	always #2 ref_clk_in = ~ref_clk_in;
	task automatic stop_test();
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic wr(input logic [7:0] pg, input logic [7:0] a,
		input logic [7:0] d);
		@(negedge ref_clk_in);
		sfr_page_in = pg;
		sfr_addr_in = a;
		sfr_wdata_in = d;
		sfr_wr_in = 1'h1;
		@(negedge ref_clk_in);
		sfr_wr_in = 1'h0;
	endtask
	task automatic rd(input logic [7:0] pg, input logic [7:0] a,
		input logic [7:0] exp, input logic hit);
		@(negedge ref_clk_in);
		sfr_page_in = pg;
		sfr_addr_in = a;
		sfr_rd_in = 1'h1;
		@(negedge ref_clk_in);
		sfr_rd_in = 1'h0;
		chk8(sfr_rdata_out, exp);
		chk1(sfr_rd_hit_out, hit);
	endtask
	// bounded wait on cmp0 rise flag (k 0) or cmp1 request (k 1)
	task automatic wait_hi(input int k);
		for (int n = 0; n < 16; n++) begin
			@(negedge ref_clk_in);
			if ((k == 0 ? cmp0_rise_flag_out : cmp1_irq_out) === 1'h1) begin
				return;
			end
		end
		bad_count++;
		$display("BAD %0t got %h exp %h", $time, 1'h0, 1'h1);
		stop_test();
	endtask
	initial begin
		repeat (4) @(negedge ref_clk_in);
		rst_b_in = 1'h1;
		foreach (r[i]) begin
			wr(r[i].wpg, r[i].wa, r[i].wd);
			rd(r[i].rpg, r[i].wa, r[i].exp, r[i].hit);
		end
		chk1(cmp1_enable_out, 1'h1);
		chk8({6'h00, cmp1_pos_hyst_out}, 8'h03);
		chk8({6'h00, cmp1_neg_hyst_out}, 8'h01);
		chk8({6'h00, cmp0_speed_mode_out}, 8'h01);
		chk8({6'h00, cmp1_speed_mode_out}, 8'h03);
		rst_b_in = 1'h0;
		repeat (4) @(negedge ref_clk_in);
		rst_b_in = 1'h1;
		rd(8'h00, 8'h9D, 8'h82, 1'h1);
		rd(8'h00, 8'h9C, 8'h82, 1'h1);
		rd(8'h00, 8'h9A, 8'h00, 1'h1);
		// cmp1 rising edge with request, then a silent falling edge
		wr(8'h00, 8'h9A, 8'h80);
		wr(8'h00, 8'h9C, 8'hA0);
		cmp_irq_src_en_in = 1'h1;
		global_irq_en_in = 1'h1;
		level[1] = 1'h1;
		wait_hi(1);
		chk1(cmp1_result_out, 1'h1);
		rd(8'h00, 8'h9A, 8'hE0, 1'h1);
		chk1(cmp_timer_out[1], 1'h1);
		wr(8'h00, 8'h9A, 8'h80);
		rd(8'h00, 8'h9A, 8'hC0, 1'h1);
		chk1(cmp1_irq_out, 1'h0);
		level[1] = 1'h0;
		repeat (12) @(negedge ref_clk_in);
		rd(8'h00, 8'h9A, 8'h90, 1'h1);
		chk1(cmp1_irq_out, 1'h0);
		chk1(cmp1_result_out, 1'h0);
		// cmp0 edges, gating and clearing
		wr(8'h03, 8'h9D, 8'hA0);
		cmp0_enable_in = 1'h1;
		level[0] = 1'h1;
		wait_hi(0);
		@(negedge ref_clk_in);
		chk1(cmp0_irq_out, 1'h1);
		chk1(cmp0_result_out, 1'h1);
		chk1(cmp_timer_out[0], 1'h1);
		global_irq_en_in = 1'h0;
		repeat (2) @(negedge ref_clk_in);
		chk1(cmp0_irq_out, 1'h0);
		cmp0_rise_clr_in = 1'h1;
		@(negedge ref_clk_in);
		cmp0_rise_clr_in = 1'h0;
		@(negedge ref_clk_in);
		chk1(cmp0_rise_flag_out, 1'h0);
		global_irq_en_in = 1'h1;
		level[0] = 1'h0;
		repeat (12) @(negedge ref_clk_in);
		chk1(cmp0_fall_flag_out, 1'h1);
		chk1(cmp0_irq_out, 1'h0);
		chk1(cmp0_result_out, 1'h0);
		cmp0_fall_clr_in = 1'h1;
		@(negedge ref_clk_in);
		cmp0_fall_clr_in = 1'h0;
		@(negedge ref_clk_in);
		chk1(cmp0_fall_flag_out, 1'h0);
		stop_test();
	end
endmodule // tb
bind dcc_regs dcc_regs_chk dcc_regs_chk_i (.ref_clk_in, .rst_b_in,
	.sfr_addr_in, .sfr_page_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in,
	.sfr_rdata_out, .sfr_rd_hit_out, .cmp_irq_src_en_in, .global_irq_en_in,
	.cmp1_enable_out, .cmp1_pos_hyst_out, .cmp1_neg_hyst_out,
	.cmp0_speed_mode_out,
	.cmp1_speed_mode_out, .cmp0_result_out, .cmp1_result_out, .cmp_timer_out,
	.cmp0_irq_out, .cmp1_irq_out);
`default_nettype wire
